// [verilog/mipe_ctrl.sv]
// mipe_ctrl.sv - per-hart interrupt pending/enable registers and take
// logic.
// Operation
// - pending register writes reach only lower-mode soft, timer, ext bits
// - delegated bits appear in lower-mode views, others read zero
// - pending bits: ext 11/9/8, timer 7/5/4, soft 3/1/0
// - enable register mirrors the pending layout bit for bit
// - machine timer pending is read-only, cleared by compare write
// - supervisor and user timer pending writable by machine software
// - lower soft pending writable at own privilege or by machine software
// - machine soft pending comes from memory-mapped register
// - external enables gate external interrupts per mode
// - supervisor external request is stored bit OR controller signal
// - swap/set/clear reads return stored bit OR controller signal
// - set/clear modify only the stored supervisor external bit
// - user external pending behaves like supervisor external pending
// - non-maskable interrupt has no pending bit
// - unsupported privilege levels have pending and enable tied zero
// - platform interrupt sources only at bit 12 and above
// - take interrupt when pending, enabled and globally enabled
// - undelegated: enabled below machine, or machine with global ie
// - delegated: enabled at that mode with its ie, or lower
// - priority machine level first, then external, software, timer per level; platform last
// - delegation uses pending bit positions
// assumes: pipeline presents one access per cycle on req_i; pin
// inputs are asynchronous; delegation bits come from elsewhere.
`timescale 1ns/1ps
`include "mipe_params.svh"

module mipe_ctrl #(
   parameter bit HAS_S = 1'b1,
   parameter bit HAS_U = 1'b1,
   parameter bit HAS_UINT = 1'b1,
   parameter int PLAT_N = 4
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // control-register port
   input wire mipe_pkg::mipe_req_t req_i,
   output logic [31:0] rdata_o,
   output logic rvalid_o,
   // hart state and delegation
   input wire mipe_pkg::mipe_hart_t hart_i,
   input wire logic [31:0] deleg_s_i,
   input wire logic [31:0] deleg_u_i,
   // interrupt sources (pins)
   input wire logic m_ext_i,
   input wire logic s_ext_i,
   input wire logic u_ext_i,
   input wire logic m_timer_i,
   input wire logic m_soft_i,
   input wire logic [PLAT_N-1:0] plat_irq_i,
   // decision
   output mipe_pkg::mipe_take_t take_o,
   output logic [31:0] pend_o
);

   localparam int NS = 5 + PLAT_N;

   // the platform field must sit between bit 12 and the top of the word
   if (PLAT_N < 1 || PLAT_N > 20) begin : g_plat_chk
      $error("PLAT_N must be 1..20");
   end

   logic [NS-1:0] pin_s;
   logic [31:0] sw_pend_r; // stored software bits
   logic [31:0] en_r;
   logic [31:0] ext_vec, pend_full, wmask_en, wmask_pend;
   logic [31:0] rd_view, rmw_base, deleg_any, newval;
   logic [31:0] plat_vec;
   logic [1:0] tgt;
   logic [4:0] cause;
   logic take;
   logic ready_me;

   // all pin sources pass two flops
   mipe_sync #(.W(NS)) u_sync (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .async_i({plat_irq_i, m_soft_i, m_timer_i, u_ext_i, s_ext_i,
                m_ext_i}),
      .sync_o(pin_s)
   );

   // fields tied zero for missing modes
   function automatic logic [31:0] impl_mask();
      logic [31:0] m;
      m = `MIPE_STD_MASK;
      if (!HAS_S) m = m & ~`MIPE_S_MASK;
      if (!HAS_U || !HAS_UINT) m = m & ~`MIPE_U_MASK;
      m = m | (((32'h1 << PLAT_N) - 32'h1) << `MIPE_PLAT_LSB);
      return m;
   endfunction

   // operation result from old value and operand
   function automatic logic [31:0] csr_op(input logic [1:0] op,
                                          input logic [31:0] old,
                                          input logic [31:0] wd);
      unique case (op)
         `MIPE_OP_SET: csr_op = old | wd;
         `MIPE_OP_CLEAR: csr_op = old & ~wd;
         default: csr_op = wd;
      endcase
   endfunction

   // assembled pending value
   always_comb begin
      plat_vec = '0;
      plat_vec[`MIPE_PLAT_LSB +: PLAT_N] = pin_s[5 +: PLAT_N];
      ext_vec = plat_vec;
      ext_vec[`MIPE_BIT_MEXT] = pin_s[0];
      ext_vec[`MIPE_BIT_SEXT] = pin_s[1];
      ext_vec[`MIPE_BIT_UEXT] = pin_s[2];
      ext_vec[`MIPE_BIT_MTIMER] = pin_s[3];
      ext_vec[`MIPE_BIT_MSOFT] = pin_s[4];
      // no non-maskable bit exists; reserved read zero
      pend_full = (sw_pend_r | ext_vec) & impl_mask();
      deleg_any = (deleg_s_i | deleg_u_i) & impl_mask();
   end

   // view, write masks and read-modify-write base per selected register
   always_comb begin
      rd_view = '0;
      rmw_base = '0;
      wmask_en = '0;
      wmask_pend = '0;
      unique case (req_i.sel)
         mipe_pkg::MIPE_SEL_M_PEND: begin
            rd_view = pend_full;
            rmw_base = sw_pend_r;
            wmask_pend = `MIPE_PEND_WMASK;
         end
         mipe_pkg::MIPE_SEL_M_EN: begin
            rd_view = en_r;
            rmw_base = en_r;
            wmask_en = impl_mask();
         end
         mipe_pkg::MIPE_SEL_S_PEND: begin
            rd_view = pend_full & deleg_s_i;
            rmw_base = sw_pend_r & deleg_s_i;
            wmask_pend = `MIPE_S_MASK & `MIPE_PEND_WMASK & deleg_s_i
               & ~(32'h1 << `MIPE_BIT_STIMER) & ~(32'h1 << `MIPE_BIT_SEXT);
         end
         mipe_pkg::MIPE_SEL_S_EN: begin
            rd_view = en_r & deleg_s_i;
            rmw_base = rd_view;
            wmask_en = deleg_s_i;
         end
         mipe_pkg::MIPE_SEL_U_PEND: begin
            rd_view = pend_full & deleg_u_i;
            rmw_base = sw_pend_r & deleg_u_i;
            wmask_pend = (32'h1 << `MIPE_BIT_USOFT) & deleg_u_i;
         end
         mipe_pkg::MIPE_SEL_U_EN: begin
            rd_view = en_r & deleg_u_i;
            rmw_base = rd_view;
            wmask_en = deleg_u_i;
         end
         default: ;
      endcase
      wmask_en = wmask_en & impl_mask();
      wmask_pend = wmask_pend & impl_mask();
      newval = csr_op(req_i.op, rmw_base, req_i.wdata);
   end

   // stored software pending bits
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         sw_pend_r <= `MIPE_RESET_VAL;
      else if (req_i.valid)
         sw_pend_r <= (sw_pend_r & ~wmask_pend) | (newval & wmask_pend);
   end

   // enable register
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i)
         en_r <= `MIPE_RESET_VAL;
      else if (req_i.valid)
         en_r <= (en_r & ~wmask_en) | (newval & wmask_en);
   end

   // read data register, one cycle after the access
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= '0;
         rvalid_o <= 1'b0;
      end else begin
         rdata_o <= req_i.valid ? rd_view : 32'h0;
         rvalid_o <= req_i.valid;
      end
   end

   // global enable for a bit per its delegation target
   function automatic logic glob_en(input logic ds, input logic du);
      logic [1:0] p;
      p = hart_i.priv;
      if (ds)
         glob_en = (p == `MIPE_PRIV_S && hart_i.s_global_ie) ||
                   (p == `MIPE_PRIV_U);
      else if (du)
         glob_en = (p == `MIPE_PRIV_U && hart_i.u_global_ie);
      else
         glob_en = (p != `MIPE_PRIV_M) || hart_i.m_global_ie;
   endfunction

   // target mode of a bit
   function automatic logic [1:0] tgt_of(input logic ds, input logic du);
      tgt_of = ds ? `MIPE_PRIV_S : (du ? `MIPE_PRIV_U : `MIPE_PRIV_M);
   endfunction

   // fixed order: machine first, ext > soft > timer within a level
   localparam logic [4:0] ORDER [9] = '{5'd11, 5'd3, 5'd7, 5'd9, 5'd1,
                                        5'd5, 5'd8, 5'd0, 5'd4};

   // priority pick among ready interrupts
   always_comb begin
      logic [31:0] ready;
      logic [4:0] b;
      ready = pend_full & en_r;
      b = '0;
      take = 1'b0;
      cause = '0;
      tgt = `MIPE_PRIV_M;
      for (int i = PLAT_N - 1; i >= 0; i--) begin
         b = 5'(`MIPE_PLAT_LSB + i);
         if (ready[b] && glob_en(1'b0, 1'b0)) begin
            take = 1'b1;
            cause = b;
         end
      end
      for (int i = 8; i >= 0; i--) begin
         b = ORDER[i];
         if (ready[b] && glob_en(deleg_s_i[b] & deleg_any[b],
                                 ~deleg_s_i[b] & deleg_u_i[b])) begin
            take = 1'b1;
            cause = b;
            tgt = tgt_of(deleg_s_i[b], ~deleg_s_i[b] & deleg_u_i[b]);
         end
      end
   end

   // registered decision and pending snapshot
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         take_o <= '0;
         pend_o <= '0;
      end else begin
         take_o <= '{take: take, target: tgt, cause: cause};
         pend_o <= pend_full;
      end
   end

   // pending write never touches read-only bits
   ro_bits_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      1'b1 |=> (sw_pend_r & ~`MIPE_PEND_WMASK) == 32'h0)
      else $error("read-only pending bit stored");
   reserved_zero_a: assert property (@(posedge clk_sys_i)
      disable iff (!resetn_i) (en_r & ~impl_mask()) == 32'h0)
      else $error("reserved enable bit set");
   s_view_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      req_i.valid && req_i.sel == mipe_pkg::MIPE_SEL_S_EN
      |=> (rdata_o & ~$past(deleg_s_i)) == 32'h0)
      else $error("undelegated bit visible");
   sext_read_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      req_i.valid && req_i.sel == mipe_pkg::MIPE_SEL_M_PEND && HAS_S
      |=> rdata_o[9] == $past(sw_pend_r[9] | pin_s[1]))
      else $error("ext read not ORed");
   sext_rmw_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      req_i.valid && req_i.sel == mipe_pkg::MIPE_SEL_M_PEND
      && req_i.op == `MIPE_OP_SET && !req_i.wdata[9] && !sw_pend_r[9]
      |=> !sw_pend_r[9])
      else $error("controller signal written back");
   take_gate_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      take |=> take_o.take && pend_o[take_o.cause])
      else $error("take without pending");
   m_global_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      hart_i.priv == `MIPE_PRIV_M && !hart_i.m_global_ie && deleg_any == 0
      |=> !take_o.take)
      else $error("machine take while disabled");
   ext_first_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      take && ready_me && glob_en(1'b0, 1'b0) && !deleg_any[11]
      |-> cause == 5'd11)
      else $error("external not first");
   u_view_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      req_i.valid && req_i.sel == mipe_pkg::MIPE_SEL_U_PEND
      |=> (rdata_o & ~$past(deleg_u_i)) == 32'h0)
      else $error("undelegated user bit visible");
   en_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      req_i.valid && req_i.sel == mipe_pkg::MIPE_SEL_M_EN
      && req_i.op == `MIPE_OP_SWAP
      |=> en_r == ($past(req_i.wdata) & impl_mask()))
      else $error("enable write not masked");
   plat_mach_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      take && cause >= 5'd12 |-> tgt == `MIPE_PRIV_M)
      else $error("platform source not machine level");

   // machine external ready, for the priority check
   assign ready_me = pend_full[11] & en_r[11];

   take_c: cover property (@(posedge clk_sys_i) take_o.take);
   deleg_c: cover property (@(posedge clk_sys_i)
      take_o.take && take_o.target == `MIPE_PRIV_S);
   rmw_c: cover property (@(posedge clk_sys_i)
      req_i.valid && req_i.op == `MIPE_OP_CLEAR);
   plat_c: cover property (@(posedge clk_sys_i)
      take_o.take && take_o.cause >= 5'd12);

endmodule // mipe_ctrl

// [common/mipe_params.svh]
// mipe_params.svh - bit positions, widths and encodings for the
// machine interrupt pending/enable block.
// assumes: included by bare name from package and design files.
`ifndef MIPE_PARAMS_SVH
`define MIPE_PARAMS_SVH

// pending / enable / delegation bit positions
`define MIPE_BIT_USOFT 0
`define MIPE_BIT_SSOFT 1
`define MIPE_BIT_MSOFT 3
`define MIPE_BIT_UTIMER 4
`define MIPE_BIT_STIMER 5
`define MIPE_BIT_MTIMER 7
`define MIPE_BIT_UEXT 8
`define MIPE_BIT_SEXT 9
`define MIPE_BIT_MEXT 11
`define MIPE_PLAT_LSB 12

// standard-field mask (bits 11, 9, 8, 7, 5, 4, 3, 1, 0)
`define MIPE_STD_MASK 32'h0000_0BBB
// bits writable through the pending register's control address
`define MIPE_PEND_WMASK 32'h0000_0333
// supervisor and user fields
`define MIPE_S_MASK 32'h0000_0222
`define MIPE_U_MASK 32'h0000_0111
// reset value of stored bits
`define MIPE_RESET_VAL 32'h0000_0000

// register operations on the control port
`define MIPE_OP_SWAP 2'h1
`define MIPE_OP_SET 2'h2
`define MIPE_OP_CLEAR 2'h3

// privilege encodings
`define MIPE_PRIV_U 2'h0
`define MIPE_PRIV_S 2'h1
`define MIPE_PRIV_M 2'h3

`endif

// [common/mipe_pkg.sv]
// mipe_pkg.sv - types for the machine interrupt pending/enable block.
// assumes: mipe_params.svh is on the include path.
`include "mipe_params.svh"

package mipe_pkg;

   // which register the control port addresses
   typedef enum logic [2:0] {
      MIPE_SEL_NONE,
      MIPE_SEL_M_PEND,
      MIPE_SEL_M_EN,
      MIPE_SEL_S_PEND,
      MIPE_SEL_S_EN,
      MIPE_SEL_U_PEND,
      MIPE_SEL_U_EN
   } mipe_sel_t;

   // one control-register access from the pipeline
   typedef struct packed {
      logic valid;
      mipe_sel_t sel;
      logic [1:0] op;
      logic [31:0] wdata;
   } mipe_req_t;

   // hart state that decides global enables
   typedef struct packed {
      logic [1:0] priv;
      logic m_global_ie;
      logic s_global_ie;
      logic u_global_ie;
   } mipe_hart_t;

   // interrupt taken toward the pipeline
   typedef struct packed {
      logic take;
      logic [1:0] target;
      logic [4:0] cause;
   } mipe_take_t;

endpackage

// [verilog/mipe_sync.sv]
// mipe_sync.sv - two-flop level synchroniser bank for pin inputs.
// assumes: single clock, asynchronous active-low reset.
`timescale 1ns/1ps

module mipe_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_r;

   // first flop feeds only the second
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule // mipe_sync

// [dv/mipe_plat_model.sv]
// mipe_plat_model.sv - platform side model: controller levels, the
// memory-mapped soft register and the machine timer compare.
// assumes: bench drives the controls on the falling edge of clk_sys_i.
`timescale 1ns/1ps

module mipe_plat_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // bench controls
   input wire logic [2:0] ext_lvl_i,
   input wire logic soft_wr_i,
   input wire logic soft_val_i,
   input wire logic cmp_wr_i,
   input wire logic [15:0] cmp_i,
   // interrupt levels toward the block
   output logic m_ext_o,
   output logic s_ext_o,
   output logic u_ext_o,
   output logic m_timer_o,
   output logic m_soft_o
);
   logic [15:0] mtime_r;
   logic [15:0] cmp_r;

   // controller levels: machine, supervisor, user external
   assign {m_ext_o, s_ext_o, u_ext_o} = ext_lvl_i;

   // free-running real-time counter
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) mtime_r <= 16'h0000;
      else mtime_r <= mtime_r + 16'h0001;
   end

   // timer posts at or past compare, held until compare is written
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmp_r <= 16'hFFFF;
         m_timer_o <= 1'b0;
      end else if (cmp_wr_i) begin
         cmp_r <= cmp_i;
         m_timer_o <= 1'b0;
      end else if (mtime_r >= cmp_r) begin
         m_timer_o <= 1'b1;
      end
   end

   // memory-mapped machine soft register
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) m_soft_o <= 1'b0;
      else if (soft_wr_i) m_soft_o <= soft_val_i;
   end
endmodule // mipe_plat_model

// [dv/tb_top.sv]
// tb_top.sv - self-checking bench for the pending/enable block.
// assumes: design and platform model compiled before this file.
`timescale 1ns/1ps
`include "mipe_params.svh"

module tb_top;
   logic clk_sys_i, resetn_i, rvalid, soft_wr, soft_val, cmp_wr;
   logic m_ext, s_ext, u_ext, m_timer, m_soft;
   logic [31:0] deleg_s, deleg_u, rdata, pend, rd;
   logic [2:0] ext_lvl;
   logic [15:0] cmp;
   logic [3:0] plat_irq;
   mipe_pkg::mipe_req_t req;
   mipe_pkg::mipe_hart_t hart;
   mipe_pkg::mipe_take_t take;
   int errors, samples_checked;

   mipe_ctrl mipe_ctrl_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .hart_i(hart),
      .deleg_s_i(deleg_s), .deleg_u_i(deleg_u), .m_ext_i(m_ext),
      .s_ext_i(s_ext), .u_ext_i(u_ext), .m_timer_i(m_timer),
      .m_soft_i(m_soft), .plat_irq_i(plat_irq), .take_o(take),
      .pend_o(pend));
   mipe_plat_model mipe_plat_model_i (.clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i), .ext_lvl_i(ext_lvl), .soft_wr_i(soft_wr),
      .soft_val_i(soft_val), .cmp_wr_i(cmp_wr), .cmp_i(cmp),
      .m_ext_o(m_ext), .s_ext_o(s_ext), .u_ext_o(u_ext),
      .m_timer_o(m_timer), .m_soft_o(m_soft));

   // 20 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask

   // an idle decision is judged on the take flag alone
   task automatic chk_take(input logic t, input logic [1:0] tg,
                           input logic [4:0] c);
      mipe_pkg::mipe_take_t e;
      e = '{take: t, target: tg, cause: c};
      samples_checked++;
      if ((t === 1'b1 && take !== e) || (t === 1'b0 && take.take !== t))
      begin
         errors++;
         $display("MISMATCH %0t take %h expected %h", $time, take, e);
      end
   endtask

   // one control-register access, answer captured into rd
   task automatic acc(input mipe_pkg::mipe_sel_t s, input logic [1:0] op,
                      input logic [31:0] wd);
      int k;
      @(negedge clk_sys_i);
      req = '{valid: 1'b1, sel: s, op: op, wdata: wd};
      @(negedge clk_sys_i);
      req.valid = 1'b0;
      k = 0;
      while (rvalid !== 1'b1 && k < 3) begin
         @(negedge clk_sys_i);
         k++;
      end
      chk32({31'h0, rvalid}, 32'h1);
      rd = rdata;
      @(negedge clk_sys_i);
   endtask

   // let pin levels cross the synchroniser and the take logic
   task automatic settle;
      repeat (5) @(negedge clk_sys_i);
   endtask

   task automatic t_reset;
      acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_SET, 32'h0);
      chk32(rd, 32'h0000_0000);
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SET, 32'h0);
      chk32(rd, 32'h0000_0000);
   endtask

   task automatic t_layout;
      acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_SWAP, 32'hFFFF_FFFF);
      settle();
      chk32(pend, 32'h0000_0333);
      acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_SWAP, 32'h0);
      chk32(rd, 32'h0000_0333);
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0000_0FFF);
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0);
      chk32(rd, 32'h0000_0BBB);
   endtask

   // stored external bit versus controller signal, both lower modes
   task automatic t_ext_or;
      for (int i = 0; i < 2; i++) begin
         ext_lvl = (i == 0) ? 3'b010 : 3'b001;
         settle();
         chk32(pend, (i == 0) ? 32'h200 : 32'h100);
         acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_SET, 32'h0);
         chk32(rd, (i == 0) ? 32'h200 : 32'h100);
         ext_lvl = 3'b000;
         settle();
         chk32(pend, 32'h0);
      end
   endtask

   task automatic t_prio;
      hart = '{priv: `MIPE_PRIV_M, m_global_ie: 1'b1, default: 1'b0};
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0000_0888);
      ext_lvl = 3'b100;
      {soft_wr, soft_val, cmp_wr, cmp} = {3'b111, 16'h0000};
      @(negedge clk_sys_i);
      {soft_wr, cmp_wr} = 2'b00;
      settle();
      chk32(pend, 32'h0000_0888);
      chk_take(1'b1, 2'h3, 5'h0B);
      ext_lvl = 3'b000;
      settle();
      chk_take(1'b1, 2'h3, 5'h03);
      {soft_wr, soft_val} = 2'b10;
      @(negedge clk_sys_i);
      soft_wr = 1'b0;
      settle();
      chk_take(1'b1, 2'h3, 5'h07);
      hart.m_global_ie = 1'b0;
      settle();
      chk_take(1'b0, 2'h0, 5'h00);
      hart.priv = `MIPE_PRIV_U;
      settle();
      chk_take(1'b1, 2'h3, 5'h07);
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0000_0080);
      ext_lvl = 3'b100;
      settle();
      chk_take(1'b1, 2'h3, 5'h07);
      {cmp_wr, cmp} = {1'b1, 16'hFFFF};
      @(negedge clk_sys_i);
      cmp_wr = 1'b0;
      settle();
      chk32(pend, 32'h0000_0800);
      ext_lvl = 3'b000;
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0);
   endtask

   // platform sources sit above bit 11 and are machine level
   task automatic t_plat;
      hart = '{priv: `MIPE_PRIV_M, m_global_ie: 1'b1, default: 1'b0};
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0000_3000);
      plat_irq = 4'h2;
      settle();
      chk32(pend, 32'h0000_2000);
      chk_take(1'b1, 2'h3, 5'h0D);
      plat_irq = 4'h0;
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0);
   endtask

   task automatic t_deleg;
      deleg_s = 32'h0000_0020;
      acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_SWAP, 32'h0000_0022);
      acc(mipe_pkg::MIPE_SEL_M_EN, `MIPE_OP_SWAP, 32'h0000_0022);
      acc(mipe_pkg::MIPE_SEL_S_PEND, `MIPE_OP_SET, 32'h0);
      chk32(rd, 32'h0000_0020);
      acc(mipe_pkg::MIPE_SEL_S_EN, `MIPE_OP_SET, 32'h0);
      chk32(rd, 32'h0000_0020);
      hart = '{priv: `MIPE_PRIV_S, default: 1'b0};
      settle();
      chk_take(1'b1, 2'h3, 5'h01);
      acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_CLEAR, 32'h0000_0002);
      settle();
      chk_take(1'b0, 2'h0, 5'h00);
      hart.s_global_ie = 1'b1;
      settle();
      chk_take(1'b1, 2'h1, 5'h05);
      hart = '{priv: `MIPE_PRIV_U, default: 1'b0};
      settle();
      chk_take(1'b1, 2'h1, 5'h05);
      deleg_u = 32'h0000_0001;
      acc(mipe_pkg::MIPE_SEL_U_PEND, `MIPE_OP_SWAP, 32'hFFFF_FFFF);
      acc(mipe_pkg::MIPE_SEL_U_PEND, `MIPE_OP_SET, 32'h0);
      chk32(rd, 32'h0000_0001);
      acc(mipe_pkg::MIPE_SEL_M_PEND, `MIPE_OP_SET, 32'h0);
      chk32(rd, 32'h0000_0021);
   endtask

   task automatic wrap_up;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog: some 4000 cycles against well under 1000 expected
   initial begin
      #200000;
      errors++;
      wrap_up();
   end

   // reset for 3 cycles, then the scenarios
   initial begin
      errors = 0;
      samples_checked = 0;
      resetn_i = 1'b0;
      req = '{valid: 1'b0, sel: mipe_pkg::MIPE_SEL_NONE, default: '0};
      hart = '{priv: `MIPE_PRIV_M, default: 1'b0};
      {deleg_s, deleg_u, ext_lvl, plat_irq} = '0;
      {soft_wr, soft_val, cmp_wr, cmp} = {3'b000, 16'hFFFF};
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      resetn_i = 1'b1;
      t_reset();
      t_layout();
      t_ext_or();
      t_prio();
      t_plat();
      t_deleg();
      wrap_up();
   end
endmodule // tb_top
